// ---- rtl/async_event_counter.sv ----
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module async_event_counter
    import aec_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [aec_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event pins, asynchronous to pclk
    input wire logic event_pin_high,
    input wire logic event_pin_low,
    // low-power hold of the control/status register
    input wire logic ctrl_hold,
    // status to the system
    output logic counter_standby,
    output logic counter_irq
);
    import aec_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [SYNC_STAGES-1:0] sync_high;
        logic [SYNC_STAGES-1:0] sync_low;
        logic last_high;
        logic last_low;
        logic [7:0] ctrl;
        logic [7:0] count_high;
        logic [7:0] count_low;
        logic [7:0] clock_stop;
        logic [1:0] irq_ctrl;
        logic armed_high;
        logic armed_low;
        logic [31:0] rdata;
        logic rd_err;
    } state_t;

    state_t s_q;
    state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // increment with wrap; bit 8 marks the FF to 00 step
    function automatic logic [8:0] inc8(input logic [7:0] v);
        inc8 = {1'b0, v} + 9'h001;
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [15:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic setup;
    logic access;
    logic wr_ctrl;
    logic rd_ctrl;
    logic wr_stop;
    logic wr_irq;
    logic mapped;
    logic edge_high;
    logic edge_low;
    logic standby;
    logic split;
    logic tick_low;
    logic tick_high;
    logic wrap_low;
    logic wrap_high;
    logic set_ovf_high;
    logic set_ovf_low;
    logic [8:0] next_low;
    logic [8:0] next_high;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    always_comb begin
        s_d = s_q;
        setup = psel & ~penable;
        access = psel & penable;
        wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;
        mapped = hit(paddr, IDX_CTRL_STATUS) | hit(paddr, IDX_COUNT_HIGH)
               | hit(paddr, IDX_COUNT_LOW) | hit(paddr, IDX_CLOCK_STOP)
               | hit(paddr, IDX_IRQ_CTRL);
        wr_ctrl = access & pwrite & pstrb[0] & hit(paddr, IDX_CTRL_STATUS);
        rd_ctrl = access & ~pwrite & hit(paddr, IDX_CTRL_STATUS);
        wr_stop = access & pwrite & pstrb[0] & hit(paddr, IDX_CLOCK_STOP);
        wr_irq = access & pwrite & pstrb[0] & hit(paddr, IDX_IRQ_CTRL);

        // pins pass two flops before the edge detector looks at them
        s_d.sync_high = {s_q.sync_high[0], event_pin_high}; // [RULE_17]
        s_d.sync_low = {s_q.sync_low[0], event_pin_low}; // [RULE_17]
        s_d.last_high = s_q.sync_high[SYNC_STAGES-1];
        s_d.last_low = s_q.sync_low[SYNC_STAGES-1];
        edge_high = s_q.sync_high[SYNC_STAGES-1] & ~s_q.last_high;
        edge_low = s_q.sync_low[SYNC_STAGES-1] & ~s_q.last_low;

        standby = ~s_q.clock_stop[BIT_STANDBY_CTRL]; // [RULE_14]
        split = s_q.ctrl[BIT_SPLIT];

        // counting; standby halts both counters
        tick_low = edge_low & s_q.ctrl[BIT_CEN_LOW] & ~standby; // [RULE_08]
        next_low = inc8(s_q.count_low);
        wrap_low = tick_low & next_low[8];
        if (split) begin
            tick_high = edge_high & s_q.ctrl[BIT_CEN_HIGH]
                      & ~standby; // [RULE_02] [RULE_07]
        end else begin
            // low byte carry clocks the high byte
            tick_high = wrap_low & s_q.ctrl[BIT_CEN_HIGH]; // [RULE_01]
        end
        next_high = inc8(s_q.count_high);
        wrap_high = tick_high & next_high[8];

        if (tick_low) begin
            s_d.count_low = next_low[7:0]; // [RULE_15] [RULE_18]
        end
        if (tick_high) begin
            s_d.count_high = next_high[7:0]; // [RULE_15] [RULE_18]
        end
        // release bits low hold the counters at zero
        if (!s_q.ctrl[BIT_REL_LOW]) begin
            s_d.count_low = RST_COUNT; // [RULE_10]
        end
        if (!s_q.ctrl[BIT_REL_HIGH]) begin
            s_d.count_high = RST_COUNT; // [RULE_09]
        end

        // edges are already in pclk, so flags see clean events
        set_ovf_high = wrap_high & ~ctrl_hold; // [RULE_03] [RULE_04] [RULE_20]
        set_ovf_low = wrap_low & split & ~ctrl_hold; // [RULE_05] [RULE_19]

        // register writes; held register ignores software
        if (wr_ctrl && !ctrl_hold && !standby) begin
            s_d.ctrl[BIT_SPARE:0] = wbyte[BIT_SPARE:0]; // [RULE_11]
            if (!wbyte[BIT_OVF_HIGH] && s_q.armed_high) begin
                s_d.ctrl[BIT_OVF_HIGH] = 1'b0; // [RULE_06]
            end
            if (!wbyte[BIT_OVF_LOW] && s_q.armed_low) begin
                s_d.ctrl[BIT_OVF_LOW] = 1'b0; // [RULE_06]
            end
            s_d.armed_high = 1'b0;
            s_d.armed_low = 1'b0;
        end
        // a read that sees a set flag arms its clear
        if (rd_ctrl) begin
            if (s_q.ctrl[BIT_OVF_HIGH]) begin
                s_d.armed_high = 1'b1; // [RULE_06]
            end
            if (s_q.ctrl[BIT_OVF_LOW]) begin
                s_d.armed_low = 1'b1; // [RULE_06]
            end
        end
        // set wins over a clear in the same cycle
        if (set_ovf_high) begin
            s_d.ctrl[BIT_OVF_HIGH] = 1'b1; // [RULE_03]
        end
        if (set_ovf_low) begin
            s_d.ctrl[BIT_OVF_LOW] = 1'b1; // [RULE_05]
        end

        if (wr_stop) begin
            s_d.clock_stop = wbyte | CLOCK_STOP_RO_MASK; // [RULE_14]
        end

        if (wr_irq) begin
            s_d.irq_ctrl[BIT_IRQ_EN] = wbyte[BIT_IRQ_EN];
            if (!wbyte[BIT_IRQ_REQ]) begin
                s_d.irq_ctrl[BIT_IRQ_REQ] = 1'b0;
            end
        end
        if (set_ovf_high || set_ovf_low) begin
            s_d.irq_ctrl[BIT_IRQ_REQ] = 1'b1; // [RULE_16]
        end

        // read data captured in setup, so zero-wait access is clean
        rbyte = 8'h00;
        if (hit(paddr, IDX_CTRL_STATUS)) begin
            rbyte = s_q.ctrl;
        end else if (hit(paddr, IDX_COUNT_HIGH)) begin
            rbyte = s_q.count_high; // [RULE_12]
        end else if (hit(paddr, IDX_COUNT_LOW)) begin
            rbyte = s_q.count_low; // [RULE_12]
        end else if (hit(paddr, IDX_CLOCK_STOP)) begin
            rbyte = s_q.clock_stop;
        end else if (hit(paddr, IDX_IRQ_CTRL)) begin
            rbyte = {6'h00, s_q.irq_ctrl};
        end
        if (setup) begin
            s_d.rdata = pwrite ? 32'h0000_0000 : {24'h000000, rbyte};
            s_d.rd_err = ~mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.sync_high <= '0;
            s_q.sync_low <= '0;
            s_q.last_high <= 1'b0;
            s_q.last_low <= 1'b0;
            s_q.ctrl <= RST_CTRL_STATUS; // [RULE_13]
            s_q.count_high <= RST_COUNT; // [RULE_12]
            s_q.count_low <= RST_COUNT; // [RULE_12]
            s_q.clock_stop <= RST_CLOCK_STOP; // [RULE_14]
            s_q.irq_ctrl <= RST_IRQ_CTRL;
            s_q.armed_high <= 1'b0;
            s_q.armed_low <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
            s_q.rd_err <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata = s_q.rdata;
    assign pready = 1'b1;
    assign pslverr = access & s_q.rd_err;
    assign counter_standby = ~s_q.clock_stop[BIT_STANDBY_CTRL];
    assign counter_irq = s_q.irq_ctrl[BIT_IRQ_REQ]
                       & s_q.irq_ctrl[BIT_IRQ_EN]; // [RULE_16]

endmodule // async_event_counter

// ---- shared/aec_pkg.sv ----
// Function
// RULE_01 - mode 0: one 16-bit counter on low pin
// RULE_02 - mode 1: two independent 8-bit counters
// RULE_03 - high wrap sets flag bit 7
// RULE_04 - 16-bit wrap reported by high flag
// RULE_05 - low wrap sets bit 6 only in split mode
// RULE_06 - flag clears by read-1 then write-0
// RULE_07 - bit 3 gates high counter events
// RULE_08 - bit 2 gates low counter events
// RULE_09 - bit 1 low holds high counter at zero
// RULE_10 - bit 0 low holds low counter at zero
// RULE_11 - bit 5 plain storage, resets zero
// RULE_12 - count registers read-only, reset zero
// RULE_13 - reset clears control/status to zero
// RULE_14 - standby bit 3, active low, resets one
// RULE_15 - 16-bit wrap continues counting from zero
// RULE_16 - any overflow sets irq request flag
// RULE_17 - counts pin edges regardless of base clocks; here standby halts both counters
// RULE_18 - 8-bit wrap sets flag, continues from zero
// RULE_19 - hold mode: count, flags untouched
// RULE_20 - overflow events synchronised before flags
package aec_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_CTRL_STATUS = 16'hff95;
    localparam logic [15:0] IDX_COUNT_HIGH = 16'hff96;
    localparam logic [15:0] IDX_COUNT_LOW = 16'hff97;
    localparam logic [15:0] IDX_CLOCK_STOP = 16'hfffb;
    localparam logic [15:0] IDX_IRQ_CTRL = 16'hfffc;

    localparam int ADDR_W = 18;

    // control/status fields
    localparam int BIT_OVF_HIGH = 7;
    localparam int BIT_OVF_LOW = 6;
    localparam int BIT_SPARE = 5;
    localparam int BIT_SPLIT = 4;
    localparam int BIT_CEN_HIGH = 3;
    localparam int BIT_CEN_LOW = 2;
    localparam int BIT_REL_HIGH = 1;
    localparam int BIT_REL_LOW = 0;

    // clock-stop and irq fields
    localparam int BIT_STANDBY_CTRL = 3;
    localparam int BIT_IRQ_REQ = 0;
    localparam int BIT_IRQ_EN = 1;

    localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_CLOCK_STOP = 8'hff;
    localparam logic [7:0] CLOCK_STOP_RO_MASK = 8'hf0;
    localparam logic [1:0] RST_IRQ_CTRL = 2'h0;

    localparam int SYNC_STAGES = 2;

endpackage

// ---- tb/aec_props.sv ----
`timescale 1ns/1ps
module aec_props (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [aec_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // status
    input wire logic counter_standby,
    input wire logic counter_irq
);
    logic wr;
    assign wr = psel && penable && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////
    a_upper_zero: assert property (prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_rdata_stable: assert property (
        !(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
    a_err_unmapped: assert property (
        psel && penable && paddr < 18'h3fe54 |-> pslverr)
        else $error("no error on unmapped address");
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    a_unmapped_zero: assert property (
        psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    a_reset_quiet: assert property (
        !$past(presetn) |-> !counter_standby && !counter_irq)
        else $error("status active after reset");
    a_standby_cause: assert property (
        $changed(counter_standby) |-> $past(wr) || $past(wr, 2))
        else $error("standby changed without a write");
    a_irq_fall: assert property (
        $fell(counter_irq) |-> $past(wr) || $past(wr, 2))
        else $error("irq dropped without a write");
    c_irq: cover property ($rose(counter_irq));
    c_err: cover property (pslverr);
    c_standby: cover property ($rose(counter_standby));
endmodule // aec_props

// ---- tb/async_event_counter_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    fail_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module async_event_counter_tb;
    import aec_pkg::*;
    typedef struct {logic [1:0] op; logic [15:0] ix; logic [8:0] v;} row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic ctrl_hold = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, counter_standby, counter_irq, ev_h, ev_l, err;
    int fail_count = 0;
    int samples_checked = 0;
    // op 0 write, 1 read and compare, 2 low pin pulses, 3 high pin pulses
    row_t rows [0:31] = '{
        '{1, IDX_CTRL_STATUS, 0}, '{1, IDX_COUNT_HIGH, 0},
        '{1, IDX_COUNT_LOW, 0}, '{1, IDX_CLOCK_STOP, 9'hff},
        '{0, IDX_COUNT_LOW, 9'h55}, '{1, IDX_COUNT_LOW, 0},
        '{0, IDX_CTRL_STATUS, 9'he0}, '{1, IDX_CTRL_STATUS, 9'h20},
        '{0, IDX_IRQ_CTRL, 9'h2}, '{0, IDX_CTRL_STATUS, 9'h1f},
        '{2, 0, 9'h100}, '{3, 0, 9'h103},
        '{0, IDX_CTRL_STATUS, 9'h1f}, '{1, IDX_CTRL_STATUS, 9'hdf},
        '{1, IDX_COUNT_HIGH, 9'h3}, '{1, IDX_COUNT_LOW, 0},
        '{0, IDX_CTRL_STATUS, 9'h1f}, '{1, IDX_CTRL_STATUS, 9'h1f},
        '{0, IDX_CTRL_STATUS, 9'hb}, '{2, 0, 9'h2},
        '{1, IDX_COUNT_LOW, 0}, '{0, IDX_CTRL_STATUS, 9'hf},
        '{2, 0, 9'h102}, '{1, IDX_COUNT_LOW, 9'h2},
        '{1, IDX_COUNT_HIGH, 9'h4}, '{1, IDX_CTRL_STATUS, 9'hf},
        '{0, IDX_CTRL_STATUS, 9'hc}, '{1, IDX_COUNT_HIGH, 0},
        '{1, IDX_COUNT_LOW, 0}, '{0, IDX_CTRL_STATUS, 9'h17},
        '{3, 0, 9'h3}, '{1, IDX_COUNT_HIGH, 0}};
    always #12.5 pclk = ~pclk;
    async_event_counter async_event_counter_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_pin_high(ev_h), .event_pin_low(ev_l), .ctrl_hold(ctrl_hold),
        .counter_standby(counter_standby), .counter_irq(counter_irq));
    event_source event_source_i (.pin_high(ev_h), .pin_low(ev_l));
    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [15:0] ix,
                       input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail_count++;
        if (n >= 20) wrap_up();
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial begin
        #1000000;
        fail_count++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].op == 2'h0) apb(1'b1, rows[i].ix, rows[i].v[7:0]);
            else if (rows[i].op == 2'h1) begin
                apb(1'b0, rows[i].ix, 8'h0);
                `CHK("register", {23'h0, rows[i].v}, q)
            end else event_source_i.pulse(rows[i].op[0], int'(rows[i].v));
        end
        $display("register table done");
        `CHK("irq set", 1'b1, counter_irq)
        apb(1'b1, IDX_IRQ_CTRL, 8'h02);
        repeat (2) @(posedge pclk);
        `CHK("irq clear", 1'b0, counter_irq)
        apb(1'b0, 16'h0, 8'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, q)
        $display("irq and map done");
        apb(1'b1, IDX_CLOCK_STOP, 8'hf7);
        repeat (2) @(posedge pclk);
        `CHK("standby", 1'b1, counter_standby)
        event_source_i.pulse(1'b0, 2);
        apb(1'b1, IDX_CLOCK_STOP, 8'hff);
        apb(1'b0, IDX_COUNT_LOW, 8'h0);
        `CHK("standby count", 32'h0, q)
        $display("standby done");
        ctrl_hold <= 1'b1;
        apb(1'b1, IDX_CTRL_STATUS, 8'h00);
        event_source_i.pulse(1'b0, 2);
        apb(1'b0, IDX_COUNT_LOW, 8'h0);
        `CHK("hold count", 32'h2, q)
        apb(1'b0, IDX_CTRL_STATUS, 8'h0);
        `CHK("hold ctrl", 32'h17, q)
        $display("hold done");
        ctrl_hold <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        `CHK("reset irq", 1'b0, counter_irq)
        apb(1'b0, IDX_CTRL_STATUS, 8'h0);
        `CHK("reset ctrl", 32'h0, q)
        apb(1'b0, IDX_COUNT_LOW, 8'h0);
        `CHK("reset count", 32'h0, q)
        apb(1'b0, IDX_CLOCK_STOP, 8'h0);
        `CHK("reset stop", 32'hff, q)
        $display("reset done");
        wrap_up();
    end
endmodule // async_event_counter_tb
bind async_event_counter aec_props aec_props_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .counter_standby(counter_standby), .counter_irq(counter_irq));

// ---- tb/event_source.sv ----
`timescale 1ns/1ps
module event_source (
    // event pins
    output logic pin_high,
    output logic pin_low
);
    initial begin
        pin_high = 1'b0;
        pin_low = 1'b0;
    end
    // 100 ns levels stay well above the two-sample synchroniser window
    task automatic pulse(input logic sel, input int n);
        #13;
        repeat (n) begin
            if (sel) pin_high = 1'b1;
            else pin_low = 1'b1;
            #100;
            pin_high = 1'b0;
            pin_low = 1'b0;
            #100;
        end
    endtask
endmodule // event_source
